// *** adc_defines.vh ***
// constants for the converter sequencer control block
`ifndef ADC_DEFINES_VH
`define ADC_DEFINES_VH

// register indices; byte address is four times the index
`define IDX_RESULT_LOW 8'h20
`define IDX_RESULT_HIGH 8'h21
`define IDX_CONTROL 8'h22
`define IDX_CLOCK_SETUP 8'h23
`define IDX_IRQ_STATUS 8'h24
`define IDX_IRQ_CLEAR 8'h25
`define IDX_IRQ_ENABLE 8'h26
`define IDX_IRQ_GLOBAL 8'h27

// control register fields
`define CTL_CHAN_LSB 0
`define CTL_CHAN_MSB 2
`define CTL_CFG_LSB 3
`define CTL_CFG_MSB 5
`define CTL_DONE_BIT 6
`define CTL_START_BIT 7

// clock setup register fields
`define CSR_SEL_LSB 0
`define CSR_SEL_MSB 1
`define CSR_TEST_BIT 7

// interrupt status layout
`define IRQ_DONE_BIT 0

// reset values
`define RST_CONTROL 8'h40
`define RST_CLOCK_SETUP 8'h00
`define RST_RESULT 12'h000

// converter clock select codes and half periods minus one in system clocks
`define CLK_SEL_DIV2 2'h0
`define CLK_SEL_DIV8 2'h1
`define CLK_SEL_DIV32 2'h2
`define HALF_DIV2 4'h0
`define HALF_DIV8 4'h3
`define HALF_DIV32 4'hF

`endif

// *** conv_clk_divider.v ***
// converter clock divider selected by the clock setup field
`timescale 1ns/1ps
module conv_clk_divider (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // control
  input wire [1:0] clk_sel,
  input wire run,
  // divided clock
  output reg conv_clk_ff
);
`include "adc_defines.vh"

  reg [3:0] cnt_ff;
  reg [3:0] half;
  reg valid;

  always @* begin
    valid = 1'b1;
    half = `HALF_DIV2;
    case (clk_sel)
      `CLK_SEL_DIV2: half = `HALF_DIV2; // [R12]
      `CLK_SEL_DIV8: half = `HALF_DIV8; // [R12]
      `CLK_SEL_DIV32: half = `HALF_DIV32; // [R12]
      default: valid = 1'b0;
    endcase
  end

  // undefined select and powered-down converter stop the clock low
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_ff <= 4'h0;
      conv_clk_ff <= 1'b0;
    end else if (!run || !valid) begin
      cnt_ff <= 4'h0;
      conv_clk_ff <= 1'b0;
    end else if (cnt_ff >= half) begin
      cnt_ff <= 4'h0;
      conv_clk_ff <= ~conv_clk_ff;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end
endmodule // conv_clk_divider

// *** adc_sequencer_control.v ***
// register file and sequencing for the eight-channel 12-bit converter
//
// How it works
// R1 - Control bits 2..0 pick which of the eight analog inputs is converted.
// R2 - Control bits 5..3 give a count n; port B pins 0..n-1 become analog. The code makes all eight pins analog for n=7.
// R3 - A zero port B count powers the converter down, nonzero keeps it on.
// R4 - Control bit 6 is an active-low done flag, 0 once conversion is over.
// R5 - A rising start bit (control bit 7) resets the converter, sets done to 1.
// R6 - Software writes start 0,1,0; converting begins on the falling edge.
// R7 - Software issues a start pulse whenever the port B count changes.
// R8 - Software finishes that start pulse within a bounded instruction count.
// R9 - Result is left-justified: high byte bits 11..4, low byte 3..0 on top.
// R10 - Clock setup bit 7 is a test bit that applications leave alone.
// R11 - Completion sets the interrupt request, gated by the two enables.
// R12 - Clock setup bits 1..0 divide the system clock by 2, 8 or 32.
// R13 - Software keeps start low until the done flag has returned to 0.
// R14 - An analog port B pin has digital I/O and pull-high disabled.
// R15 - Results update no later than done clears and the request rises.
// R16 - Result registers are read-only; writes leave them unchanged.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module adc_sequencer_control (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_ff,
  output reg pready_ff,
  output reg pslverr_ff,
  // interrupt
  output reg irq_ff,
  // analog conversion core
  input wire core_done,
  input wire [11:0] core_result,
  output reg [2:0] analog_inputs_sel_ff,
  output reg conv_power_en_ff,
  output reg conv_reset_ff,
  output reg conv_start_ff,
  output wire conv_clk_ff,
  output reg test_mode_ff,
  // port B pin control
  output reg [7:0] portb_pins_analog_ff,
  output reg [7:0] portb_pullhigh_dis_ff
);
`include "adc_defines.vh"

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_ARMED = 3'b010;
  localparam [2:0] ST_CONV = 3'b100;

  // reset images of the control and clock setup registers
  localparam [7:0] RST_CTL = `RST_CONTROL;
  localparam [7:0] RST_CSR = `RST_CLOCK_SETUP;

  // software-visible state
  reg [2:0] chan_sel_ff;
  reg [2:0] portb_cfg_ff;
  reg conv_done_n_ff;
  reg start_ff;
  reg start_prev_ff;
  reg [1:0] conv_clk_sel_ff;
  reg test_bit_ff;
  reg [11:0] result_ff;
  reg conv_irq_request_ff;
  reg conv_irq_enable_ff;
  reg global_irq_enable_ff;
  reg [2:0] state_ff;

  // next values
  reg [2:0] nxt_state;
  reg nxt_conv_done_n;
  reg [11:0] nxt_result;
  reg nxt_irq_request;
  reg [7:0] nxt_analog;

  // bus decode
  wire access_phase;
  wire wr_en;
  wire rd_en;
  wire addr_mapped;
  wire [7:0] idx;
  // one select per register word
  wire sel_result_low;
  wire sel_result_high;
  wire sel_control;
  wire sel_clock_setup;
  wire sel_irq_status;
  wire sel_irq_clear;
  wire sel_irq_enable;
  wire sel_irq_global;
  wire start_rise;
  wire start_fall;
  wire done_event;
  wire irq_clear_done;
  reg [7:0] rd_byte;

  assign access_phase = psel && penable;
  assign idx = {2'b00, paddr[7:2]};
  assign addr_mapped = (paddr[1:0] == 2'b00) &&
    (idx >= `IDX_RESULT_LOW) && (idx <= `IDX_IRQ_GLOBAL);
  assign sel_result_low = addr_mapped && (idx == `IDX_RESULT_LOW);
  assign sel_result_high = addr_mapped && (idx == `IDX_RESULT_HIGH);
  assign sel_control = addr_mapped && (idx == `IDX_CONTROL);
  assign sel_clock_setup = addr_mapped && (idx == `IDX_CLOCK_SETUP);
  assign sel_irq_status = addr_mapped && (idx == `IDX_IRQ_STATUS);
  assign sel_irq_clear = addr_mapped && (idx == `IDX_IRQ_CLEAR);
  assign sel_irq_enable = addr_mapped && (idx == `IDX_IRQ_ENABLE);
  assign sel_irq_global = addr_mapped && (idx == `IDX_IRQ_GLOBAL);
  // the transfer completes on the edge where pready_ff is already high
  assign wr_en = access_phase && pready_ff && pwrite && addr_mapped;
  assign rd_en = access_phase && !pready_ff && !pwrite;

  assign start_rise = start_ff && !start_prev_ff;
  assign start_fall = !start_ff && start_prev_ff;
  // a completion only counts while converting with power on
  assign done_event = core_done && (state_ff == ST_CONV) &&
    conv_power_en_ff;
  assign irq_clear_done = wr_en && sel_irq_clear &&
    pwdata[`IRQ_DONE_BIT];

  // apb handshake: one wait state, answer from flip-flops
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end else if (access_phase && !pready_ff) begin
      pready_ff <= 1'b1;
      pslverr_ff <= !addr_mapped;
      prdata_ff <= rd_en ? {24'h000000, rd_byte} : 32'h00000000;
    end else begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h00000000;
    end
  end

  // read mux; unused and write-only bits read as zero
  always @* begin
    rd_byte = 8'h00;
    if (sel_result_low) begin
      rd_byte = {result_ff[3:0], 4'h0}; // [R9]
    end else if (sel_result_high) begin
      rd_byte = result_ff[11:4]; // [R9]
    end else if (sel_control) begin
      rd_byte = {start_ff, conv_done_n_ff, portb_cfg_ff, chan_sel_ff}; // [R4]
    end else if (sel_clock_setup) begin
      rd_byte = {test_bit_ff, 5'h00, conv_clk_sel_ff};
    end else if (sel_irq_status) begin
      rd_byte = {7'h00, conv_irq_request_ff};
    end else if (sel_irq_enable) begin
      rd_byte = {7'h00, conv_irq_enable_ff};
    end else if (sel_irq_global) begin
      rd_byte = {7'h00, global_irq_enable_ff};
    end
  end

  // writable fields, one per process; result registers ignore writes
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chan_sel_ff <= RST_CTL[`CTL_CHAN_MSB:`CTL_CHAN_LSB];
    end else if (wr_en && sel_control) begin
      chan_sel_ff <= pwdata[`CTL_CHAN_MSB:`CTL_CHAN_LSB]; // [R1]
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      portb_cfg_ff <= RST_CTL[`CTL_CFG_MSB:`CTL_CFG_LSB];
    end else if (wr_en && sel_control) begin
      portb_cfg_ff <= pwdata[`CTL_CFG_MSB:`CTL_CFG_LSB]; // [R2]
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      start_ff <= RST_CTL[`CTL_START_BIT];
    end else if (wr_en && sel_control) begin
      start_ff <= pwdata[`CTL_START_BIT]; // [R6]
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      conv_clk_sel_ff <= RST_CSR[`CSR_SEL_MSB:`CSR_SEL_LSB];
    end else if (wr_en && sel_clock_setup) begin
      conv_clk_sel_ff <= pwdata[`CSR_SEL_MSB:`CSR_SEL_LSB]; // [R12]
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      test_bit_ff <= RST_CSR[`CSR_TEST_BIT];
    end else if (wr_en && sel_clock_setup) begin
      test_bit_ff <= pwdata[`CSR_TEST_BIT]; // [R10]
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      conv_irq_enable_ff <= 1'b0;
    end else if (wr_en && sel_irq_enable) begin
      conv_irq_enable_ff <= pwdata[`IRQ_DONE_BIT]; // [R11]
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      global_irq_enable_ff <= 1'b0;
    end else if (wr_en && sel_irq_global) begin
      global_irq_enable_ff <= pwdata[0]; // [R11]
    end
  end

  // start edge tracking
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      start_prev_ff <= 1'b0;
    end else begin
      start_prev_ff <= start_ff;
    end
  end

  // conversion sequencer
  always @* begin
    nxt_state = state_ff;
    nxt_conv_done_n = conv_done_n_ff;
    nxt_result = result_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start_rise) begin
          nxt_state = ST_ARMED;
        end
      end
      ST_ARMED: begin
        if (start_fall) begin
          nxt_state = ST_CONV; // [R6]
        end
      end
      ST_CONV: begin
        if (start_rise) begin
          nxt_state = ST_ARMED; // [R13]
        end else if (done_event) begin
          nxt_state = ST_IDLE;
          nxt_result = core_result; // [R15]
          nxt_conv_done_n = 1'b0; // [R4]
        end else if (!conv_power_en_ff) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (start_rise) begin
      nxt_conv_done_n = 1'b1; // [R5]
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      conv_done_n_ff <= RST_CTL[`CTL_DONE_BIT];
      result_ff <= `RST_RESULT;
      conv_reset_ff <= 1'b0;
      conv_start_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      conv_done_n_ff <= nxt_conv_done_n;
      result_ff <= nxt_result; // [R16]
      conv_reset_ff <= start_rise; // [R5]
      conv_start_ff <= start_fall && (state_ff == ST_ARMED); // [R6]
    end
  end

  // sticky request: a new completion beats a clear in the same cycle
  always @* begin
    nxt_irq_request = conv_irq_request_ff & ~irq_clear_done;
    if (done_event) begin
      nxt_irq_request = 1'b1; // [R11]
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      conv_irq_request_ff <= 1'b0;
    end else begin
      conv_irq_request_ff <= nxt_irq_request;
    end
  end

  // level output: pending request gated by both enables
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq_request && conv_irq_enable_ff &&
        global_irq_enable_ff; // [R11]
    end
  end

  // port B analog selection, one bit per pin
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
      always @* begin
        if (portb_cfg_ff == 3'h7) begin
          nxt_analog[gi] = 1'b1; // [R2]
        end else begin
          nxt_analog[gi] = (gi < portb_cfg_ff); // [R2]
        end
      end
    end
  endgenerate

  // converter controls
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      analog_inputs_sel_ff <= 3'h0;
      conv_power_en_ff <= 1'b0;
      test_mode_ff <= 1'b0;
    end else begin
      analog_inputs_sel_ff <= chan_sel_ff; // [R1]
      conv_power_en_ff <= (portb_cfg_ff != 3'h0); // [R3]
      test_mode_ff <= test_bit_ff;
    end
  end

  // pin controls: analog pins lose digital I/O and pull-high
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      portb_pins_analog_ff <= 8'h00;
      portb_pullhigh_dis_ff <= 8'h00;
    end else begin
      portb_pins_analog_ff <= nxt_analog; // [R14]
      portb_pullhigh_dis_ff <= nxt_analog; // [R14]
    end
  end

  conv_clk_divider u_div (
    .sys_clk(sys_clk),
    .rst(rst),
    .clk_sel(conv_clk_sel_ff),
    .run(conv_power_en_ff),
    .conv_clk_ff(conv_clk_ff)
  ); // [R12]

endmodule // adc_sequencer_control

// *** adc_props.sv ***
// property checker for the converter sequencer
`timescale 1ns/1ps
module adc_props (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire pready_ff,
  input wire pslverr_ff,
  // converter and pins
  input wire irq_ff,
  input wire [2:0] analog_inputs_sel_ff,
  input wire conv_power_en_ff,
  input wire conv_reset_ff,
  input wire conv_start_ff,
  input wire conv_clk_ff,
  input wire [7:0] portb_pins_analog_ff,
  input wire [7:0] portb_pullhigh_dis_ff
);
  wire wr_ctl = psel && penable && pwrite && pready_ff && paddr == 8'h88;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_ready_wait: assert property (psel && !penable |=> !pready_ff ##1
    pready_ff) else $error("apb answer late");
  a_err_ready: assert property (pslverr_ff |-> pready_ff)
    else $error("error without ready");
  a_chan_sel: assert property (wr_ctl |-> ##2
    analog_inputs_sel_ff == $past(pwdata[2:0], 2)) else $error("chan");
  a_power_cfg: assert property (wr_ctl |-> ##2
    conv_power_en_ff == ($past(pwdata[5:3], 2) != 3'h0)) else $error("pwr");
  a_pins_contig: assert property (((portb_pins_analog_ff + 8'h01) &
    portb_pins_analog_ff) == 8'h00) else $error("pins");
  a_pullhigh_same: assert property (
    portb_pullhigh_dis_ff == portb_pins_analog_ff) else $error("pull");
  a_reset_pulse: assert property (conv_reset_ff |->
    $past(wr_ctl && pwdata[7], 2) ##1 !conv_reset_ff) else $error("rst");
  a_start_pulse: assert property (conv_start_ff |->
    $past(wr_ctl && !pwdata[7], 2) ##1 !conv_start_ff) else $error("go");
  a_clk_off: assert property (!conv_power_en_ff [*3] |->
    !conv_clk_ff) else $error("clock while off");
  c_start: cover property (conv_start_ff);
  c_irq: cover property ($rose(irq_ff));
  c_err: cover property (pslverr_ff);
endmodule // adc_props
bind adc_sequencer_control adc_props i_props (.*);

// *** adc_core_model.sv ***
// behavioural analog conversion core
`timescale 1ns/1ps
module adc_core_model (
  // clock and reset
  input wire sys_clk,
  input wire rst,
  // from the sequencer
  input wire power,
  input wire conv_reset,
  input wire conv_start,
  input wire [2:0] chan,
  // to the sequencer
  output reg core_done,
  output reg [11:0] core_result
);
  int lat = 4;
  int cnt;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      core_done <= 1'b0;
      core_result <= 12'hFFF;
    end else begin
      core_done <= 1'b0;
      core_result <= ~core_result;
      if (!power || conv_reset)
        cnt <= 0;
      else if (conv_start)
        cnt <= lat;
      else if (cnt > 0) begin
        cnt <= cnt - 1;
        if (cnt == 1) begin
          core_done <= 1'b1;
          core_result <= {chan, ~chan, 3'h5, chan};
        end
      end
    end
  end
endmodule // adc_core_model

// *** testbench.sv ***
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
  failures++; $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module testbench;
  logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata_ff, rdat;
  logic pready_ff, pslverr_ff, irq_ff, core_done, rerr;
  logic [11:0] core_result, ex;
  logic [2:0] analog_inputs_sel_ff;
  logic conv_power_en_ff, conv_reset_ff, conv_start_ff;
  logic conv_clk_ff, test_mode_ff;
  logic [7:0] portb_pins_analog_ff, portb_pullhigh_dis_ff;
  int failures = 0, check_count = 0, n;
  always #20 sys_clk = ~sys_clk;
  adc_sequencer_control i_adc_sequencer_control (.*);
  adc_core_model i_adc_core_model (.sys_clk(sys_clk), .rst(rst),
    .power(conv_power_en_ff), .conv_reset(conv_reset_ff),
    .conv_start(conv_start_ff), .chan(analog_inputs_sel_ff),
    .core_done(core_done), .core_result(core_result));
  task automatic xfer(input [7:0] a, input w, input [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready_ff !== 1'b1 && k < 50);
    if (k == 50)
      failures++;
    rdat = prdata_ff;
    rerr = pslverr_ff;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic conv(input [2:0] c, input [2:0] cfg);
    int k;
    xfer(8'h88, 1, {24'h0, 2'b10, cfg, c});
    xfer(8'h88, 0, 0);
    `CHK("done_set", 1'b1, rdat[6])
    xfer(8'h88, 1, {24'h0, 2'b00, cfg, c});
    k = 0;
    do begin
      xfer(8'h88, 0, 0);
      k++;
    end while (rdat[6] !== 1'b0 && k < 40);
    `CHK("done_clr", 1'b0, rdat[6])
    ex = {c, ~c, 3'h5, c};
    xfer(8'h84, 0, 0);
    `CHK("res_hi", ex[11:4], rdat[7:0])
    xfer(8'h80, 0, 0);
    `CHK("res_lo", {ex[3:0], 4'h0}, rdat[7:0])
  endtask
  task finish_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #(40 * 20000);
    failures++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    xfer(8'h88, 0, 0);
    `CHK("ctl_rst", 8'h40, rdat[7:0])
    for (int i = 0; i < 8; i++) begin
      xfer(8'h88, 1, 32'h80 | i << 3);
      xfer(8'h88, 1, i << 3);
      @(posedge sys_clk);
      rdat = (i == 7) ? 32'hFF : (32'h1 << i) - 32'h1;
      `CHK("pins", rdat[7:0], portb_pins_analog_ff)
      `CHK("pullhi", portb_pins_analog_ff, portb_pullhigh_dis_ff)
      `CHK("power", i != 0, conv_power_en_ff)
    end
    for (int c = 0; c < 8; c++) begin
      i_adc_core_model.lat = 2 + c * 4;
      conv(3'(c), 3'(c | 1));
    end
    xfer(8'h80, 1, 32'hFF);
    xfer(8'h80, 0, 0);
    `CHK("res_ro", {ex[3:0], 4'h0}, rdat[7:0])
    xfer(8'h94, 1, 1);
    xfer(8'h98, 1, 1);
    xfer(8'h9C, 1, 1);
    conv(3'd2, 3'd5);
    `CHK("irq_on", 1'b1, irq_ff)
    xfer(8'h90, 0, 0);
    `CHK("status", 8'h01, rdat[7:0])
    xfer(8'h94, 1, 1);
    @(posedge sys_clk);
    `CHK("irq_clr", 1'b0, irq_ff)
    xfer(8'h9C, 1, 0);
    conv(3'd6, 3'd5);
    `CHK("irq_mask", 1'b0, irq_ff)
    xfer(8'h9C, 1, 1);
    @(posedge sys_clk);
    `CHK("irq_unmask", 1'b1, irq_ff)
    xfer(8'hFC, 0, 0);
    `CHK("unmapped", 33'h100000000, {rerr, rdat})
    xfer(8'h89, 1, 0);
    `CHK("misalign", 1'b1, rerr)
    for (int s = 0; s < 3; s++) begin
      xfer(8'h8C, 1, s);
      xfer(8'h8C, 0, 0);
      `CHK("clk_sel", s[7:0], rdat[7:0])
      @(posedge conv_clk_ff);
      @(posedge conv_clk_ff);
      n = 0;
      do begin
        @(posedge sys_clk);
        n++;
      end while (conv_clk_ff && n < 40);
      `CHK("half", 2 ** (2 * s) + 1, n)
    end
    `CHK("test", 1'b0, test_mode_ff)
    finish_test();
  end
endmodule // testbench
